// ---- common/afrms_defs.svh ----
/*
  register offsets, field positions, reset values and timing counts of the
  acceleration filter and RMS path; assumes a 25 MHz clock
*/
`ifndef AFRMS_DEFS_SVH
`define AFRMS_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define AFRMS_OFS_RATE   8'h64
`define AFRMS_OFS_ROUTE  8'h65
`define AFRMS_OFS_F1IA   8'h66
`define AFRMS_OFS_BA_LO  8'h67
`define AFRMS_OFS_BA_MI  8'h68
`define AFRMS_OFS_BA_HI  8'h69
`define AFRMS_OFS_CA_LO  8'h6a
`define AFRMS_OFS_CA_MI  8'h6b
`define AFRMS_OFS_CA_HI  8'h6c
`define AFRMS_OFS_ISH    8'h6d
`define AFRMS_OFS_OSH    8'h6e

// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define AFRMS_RST_ROUTE  8'h02
`define AFRMS_RST_ZERO   8'h00
`define AFRMS_MSK_FULL   8'hff
`define AFRMS_MSK_ROUTE  8'hfb
`define AFRMS_MSK_7B     8'h7f
`define AFRMS_MSK_ISH    8'h1f

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define AFRMS_B_BUFSEL   7
`define AFRMS_B_WISEL    6
`define AFRMS_B_WRMS     5
`define AFRMS_B_F2BYP    4
`define AFRMS_B_F1BYP    3
`define AFRMS_B_RMSO     1
`define AFRMS_B_F2HP     0
`define AFRMS_B_F1OSH    7

// ----------------------------------------------------------------------
// timing: top path rate and the clock
// ----------------------------------------------------------------------
`define AFRMS_CLK_HZ     25000000
`define AFRMS_TOP_HZ     25600
`define AFRMS_BASE_CYC   (`AFRMS_CLK_HZ / `AFRMS_TOP_HZ)
`define AFRMS_RATE_TOP   15

`endif

// ---- common/afrms_pkg.sv ----
/*
  types shared by the acceleration filter and RMS path; assumes nothing
*/
package afrms_pkg;

  // source feeding the wake and sleep engines
  typedef enum logic [1:0] {
    AFRMS_WS_RAW  = 2'b00,
    AFRMS_WS_NONE = 2'b01,
    AFRMS_WS_RMS  = 2'b10
  } afrms_wsrc_e;

endpackage : afrms_pkg

// ---- rtl/afrms_buf2.sv ----
/*
  two-entry buffer with valid and ready on both sides; assumes one clock
  and an active-low asynchronous reset
*/
`timescale 1ns/100ps

module afrms_buf2 #(
  parameter int W = 48
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } afrms_buf_s;

  afrms_buf_s s;
  afrms_buf_s next_s;

  // full and empty come straight from the count
  assign in_ready  = (s.cnt != 2'd2);
  assign out_valid = (s.cnt != 2'd0);
  assign out_data  = s.mem[s.rp];

  // push and pop
  always_comb begin
    next_s = s;
    if (in_valid && in_ready) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp        = ~s.wp;
    end
    if (out_valid && out_ready) begin
      next_s.rp = ~s.rp;
    end
    next_s.cnt = 2'(s.cnt + (in_valid && in_ready) - (out_valid && out_ready));
  end

  // state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : afrms_buf2

// ---- rtl/afrms_path.sv ----
/*
  acceleration filter and RMS path: pre-averaging, two filter stages,
  RMS stage, routing to output registers, sample buffer and wake engines.
  assumes samples arrive on the same clock and registers are written
  through a simple byte-wide strobe port.
*/
`timescale 1ns/100ps
`include "afrms_defs.svh"

// Summary of operation
// - path runs only while the engine enable input is one
// - path output always goes to output registers, and also to the buffer when bit 7 picks path data
// - configuration writes are taken at any time, sampling continues
// - RMS uses 2 to the power code plus one samples
// - input samples are first averaged per the low-power count
// - path rate code 0 is 0.781 Hz, doubling to 25600 Hz
// - filter results at path rate, RMS at path rate over count
// - path-fed wake engines take path rate and RMS count
// - buffer source bit picks raw data or path data
// - wake input bit picks raw data or path data
// - wake RMS bit gives RMS or nothing when path is chosen
// - bit 4 bypasses filter two, bit 3 bypasses filter one
// - bit 1 picks filter or RMS output; software keeps it consistent
// - filter one 1/A is seven low bits
// - filter one B/A is 23 bits over three registers, low first
// - filter one C/A is 23 bits over three registers, low first
// - filter one input shift is a five-bit field
// - filter one output shift is the top bit of shared register
// - filter two 1/A is the low seven bits of that register
module afrms_path #(
  parameter int DW       = 16,
  parameter int BASE_CYC = `AFRMS_BASE_CYC
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          resetn,
  // engine controls held elsewhere
  input  wire logic          path_engine_enable,
  input  wire logic [2:0]    lowpower_average_count,
  // register port
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output logic [7:0]         reg_rdata,
  // sample stream
  input  wire logic          smp_valid,
  output logic               smp_ready,
  input  wire logic [DW-1:0] smp_x,
  input  wire logic [DW-1:0] smp_y,
  input  wire logic [DW-1:0] smp_z,
  // path output registers
  output logic               path_out_valid,
  output logic [DW-1:0]      path_x_output,
  output logic [DW-1:0]      path_y_output,
  output logic [DW-1:0]      path_z_output,
  // sample buffer side
  output logic               buf_valid,
  input  wire logic          buf_ready,
  output logic [DW-1:0]      buf_x,
  output logic [DW-1:0]      buf_y,
  output logic [DW-1:0]      buf_z,
  // wake and sleep engines
  output logic               wake_valid,
  output logic [DW-1:0]      wake_x,
  output logic [DW-1:0]      wake_y,
  output logic [DW-1:0]      wake_z,
  output logic               wake_rate_override,
  output logic [2:0]         wake_avg_count
);

  // ----------------------------------------------------------------------
  // register indices and state
  // ----------------------------------------------------------------------
  localparam logic [7:0] BASE = `AFRMS_OFS_RATE;
  localparam int I_ROUTE = int'(`AFRMS_OFS_ROUTE - BASE);
  localparam int I_F1IA  = int'(`AFRMS_OFS_F1IA - BASE);
  localparam int I_BALO  = int'(`AFRMS_OFS_BA_LO - BASE);
  localparam int I_BAHI  = int'(`AFRMS_OFS_BA_HI - BASE);
  localparam int I_CALO  = int'(`AFRMS_OFS_CA_LO - BASE);
  localparam int I_CAHI  = int'(`AFRMS_OFS_CA_HI - BASE);
  localparam int I_ISH   = int'(`AFRMS_OFS_ISH - BASE);
  localparam int I_OSH   = int'(`AFRMS_OFS_OSH - BASE);
  localparam int NREG    = I_OSH + 1;

  typedef struct packed {
    logic [NREG-1:0][7:0] cfg;
    logic [7:0]           rdata;
    logic [15:0]          base_cnt;
    logic [14:0]          pre_cnt;
    logic [7:0]           avg_n;
    logic [2:0][23:0]     avg_acc;
    logic [2:0][DW-1:0]   avg_smp;
    logic [2:0][DW-1:0]   f1_y1;
    logic [2:0][DW-1:0]   f1_y2;
    logic [2:0][DW-1:0]   f2_lp;
    logic [7:0]           rms_n;
    logic [2:0][39:0]     rms_acc;
    logic [2:0][DW-1:0]   path_out;
    logic                 path_vld;
    logic [2:0][DW-1:0]   wake_out;
    logic                 wake_vld;
    logic                 pend;
  } afrms_state_s;

  afrms_state_s       s;
  afrms_state_s       next_s;
  logic               base_tick;
  logic               path_tick;
  logic               rms_done;
  logic               hit;
  logic [3:0]         idx;
  logic               bin_valid;
  logic               bin_ready;
  logic [3*DW-1:0]    bin_data;
  logic [3*DW-1:0]    bout_data;
  logic [2:0][DW-1:0] smp;
  afrms_pkg::afrms_wsrc_e wsrc;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic signed [47:0] afrms_sx(input logic [DW-1:0] v);
    return 48'($signed(v));
  endfunction : afrms_sx

  function automatic logic [DW-1:0] afrms_sat(input logic signed [47:0] v);
    logic signed [47:0] hi;
    hi = 48'((64'sd1 <<< (DW - 1)) - 1);
    if (v > hi) return hi[DW-1:0];
    if (v < -hi - 1) return DW'(-hi - 1);
    return v[DW-1:0];
  endfunction : afrms_sat

  function automatic logic [15:0] afrms_isqrt(input logic [31:0] v);
    logic [15:0] r;
    logic [31:0] t;
    r = '0;
    t = '0;
    for (int b = 15; b >= 0; b--) begin
      t = 32'(r | (16'h0001 << b));
      if (32'(t * t) <= v) r = r | (16'h0001 << b);
    end
    return r;
  endfunction : afrms_isqrt

  function automatic logic [7:0] afrms_mask(input logic [3:0] i);
    case (int'(i))
      I_ROUTE:                 return `AFRMS_MSK_ROUTE;
      I_F1IA, I_BAHI, I_CAHI:  return `AFRMS_MSK_7B;
      I_ISH:                   return `AFRMS_MSK_ISH;
      default:                 return `AFRMS_MSK_FULL;
    endcase
  endfunction : afrms_mask

  // address decode and fixed routing views
  assign hit  = (reg_addr >= BASE) && (reg_addr <= 8'(BASE + 8'(NREG - 1)));
  assign idx  = 4'(reg_addr - BASE);
  assign smp  = {smp_z, smp_y, smp_x};
  assign wsrc = !s.cfg[I_ROUTE][`AFRMS_B_WISEL] ? afrms_pkg::AFRMS_WS_RAW :
                 s.cfg[I_ROUTE][`AFRMS_B_WRMS]  ? afrms_pkg::AFRMS_WS_RMS :
                                                  afrms_pkg::AFRMS_WS_NONE;

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic signed [47:0] xs, a1, lpn;
    logic [DW-1:0]      mid, fin;
    logic [39:0]        racc;
    logic [23:0]        asum;
    logic [14:0]        lmask;
    logic [3:0]         rate;
    logic [2:0]         rcnt;
    logic [7:0]         route;
    xs     = '0;
    a1     = '0;
    lpn    = '0;
    mid    = '0;
    fin    = '0;
    racc   = '0;
    asum   = '0;
    rate   = s.cfg[0][3:0];
    rcnt   = s.cfg[0][6:4];
    route  = s.cfg[I_ROUTE];
    lmask  = 15'((32'd1 << (`AFRMS_RATE_TOP - int'(rate))) - 1);
    next_s = s;
    next_s.path_vld = 1'b0;
    next_s.wake_vld = 1'b0;
    // register writes at any time, reserved bits kept at zero
    if (reg_wr && hit) next_s.cfg[idx] = reg_wdata & afrms_mask(idx);
    if (reg_rd) next_s.rdata = hit ? s.cfg[idx] : 8'h00;
    // base timer at the top rate, prescaler divides by powers of two
    base_tick = (s.base_cnt == 16'(BASE_CYC - 1));
    next_s.base_cnt = base_tick ? '0 : 16'(s.base_cnt + 16'd1);
    if (base_tick) next_s.pre_cnt = 15'(s.pre_cnt + 15'd1);
    path_tick = base_tick && ((s.pre_cnt & lmask) == lmask)
                && path_engine_enable && !s.pend;
    // pre-averaging of incoming samples
    if (smp_valid && smp_ready) begin
      for (int i = 0; i < 3; i++) begin
        asum = 24'(s.avg_acc[i] + 24'($signed(smp[i])));
        if (s.avg_n == 8'((1 << lowpower_average_count) - 1)) begin
          next_s.avg_smp[i] = DW'($signed(asum) >>> lowpower_average_count);
          next_s.avg_acc[i] = '0;
        end else begin
          next_s.avg_acc[i] = asum;
        end
      end
      next_s.avg_n = (s.avg_n == 8'((1 << lowpower_average_count) - 1)) ? '0 :
                     8'(s.avg_n + 8'd1);
    end
    // filter and RMS stages
    rms_done = path_tick && (s.rms_n == 8'((2 << rcnt) - 1));
    if (!path_engine_enable) begin
      next_s.f1_y1   = '0;
      next_s.f1_y2   = '0;
      next_s.f2_lp   = '0;
      next_s.rms_acc = '0;
      next_s.rms_n   = '0;
    end else if (path_tick) begin
      next_s.rms_n = rms_done ? '0 : 8'(s.rms_n + 8'd1);
      for (int i = 0; i < 3; i++) begin
        xs = afrms_sx(s.avg_smp[i]) >>> s.cfg[I_ISH][4:0];
        a1 = ((xs * $signed({1'b0, s.cfg[I_F1IA][6:0]})) >>> 6)
           + ((afrms_sx(s.f1_y1[i]) * $signed({s.cfg[I_BAHI][6:0],
               s.cfg[I_BALO + 1], s.cfg[I_BALO]})) >>> 22)
           - ((afrms_sx(s.f1_y2[i]) * $signed({s.cfg[I_CAHI][6:0],
               s.cfg[I_CALO + 1], s.cfg[I_CALO]})) >>> 22);
        if (s.cfg[I_OSH][`AFRMS_B_F1OSH]) a1 = a1 >>> 1;
        mid = route[`AFRMS_B_F1BYP] ? s.avg_smp[i] : afrms_sat(a1);
        if (!route[`AFRMS_B_F1BYP]) begin
          next_s.f1_y2[i] = s.f1_y1[i];
          next_s.f1_y1[i] = mid;
        end
        lpn = afrms_sx(s.f2_lp[i]) + (((afrms_sx(mid) - afrms_sx(s.f2_lp[i]))
              * $signed({1'b0, s.cfg[I_OSH][6:0]})) >>> 7);
        if (route[`AFRMS_B_F2BYP]) begin
          fin = mid;
        end else begin
          next_s.f2_lp[i] = afrms_sat(lpn);
          fin = route[`AFRMS_B_F2HP] ? afrms_sat(afrms_sx(mid) - lpn)
                                     : afrms_sat(lpn);
        end
        racc = 40'(s.rms_acc[i] + 40'(afrms_sx(fin) * afrms_sx(fin)));
        next_s.rms_acc[i] = rms_done ? '0 : racc;
        if (!route[`AFRMS_B_RMSO]) begin
          next_s.path_out[i] = fin;
        end else if (rms_done) begin
          next_s.path_out[i] = DW'(afrms_isqrt(32'(racc >> (4'(rcnt) + 4'd1))));
        end
        if (wsrc == afrms_pkg::AFRMS_WS_RMS && rms_done) begin
          next_s.wake_out[i] = DW'(afrms_isqrt(32'(racc >> (4'(rcnt) + 4'd1))));
        end
      end
      next_s.path_vld = !route[`AFRMS_B_RMSO] || rms_done;
      next_s.wake_vld = (wsrc == afrms_pkg::AFRMS_WS_RMS) && rms_done;
    end
    // raw samples to the wake engines
    if (wsrc == afrms_pkg::AFRMS_WS_RAW && smp_valid) begin
      next_s.wake_out = smp;
      next_s.wake_vld = 1'b1;
    end
    // a path word waits here until the buffer takes it
    if (s.pend && bin_ready) next_s.pend = 1'b0;
    if (next_s.path_vld && route[`AFRMS_B_BUFSEL]) next_s.pend = 1'b1;
  end

  // state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s                 <= '0;
      s.cfg[I_ROUTE]    <= `AFRMS_RST_ROUTE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // sample buffer feed
  // ----------------------------------------------------------------------
  // raw words pass straight in; path words come from the output registers
  assign bin_valid = s.cfg[I_ROUTE][`AFRMS_B_BUFSEL] ? s.pend : smp_valid;
  assign bin_data  = s.cfg[I_ROUTE][`AFRMS_B_BUFSEL] ? s.path_out : smp;
  assign smp_ready = s.cfg[I_ROUTE][`AFRMS_B_BUFSEL] ? 1'b1 : bin_ready;

  afrms_buf2 #(
    .W (3 * DW)
  ) u_buf (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (bin_valid),
    .in_ready  (bin_ready),
    .in_data   (bin_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (bout_data)
  );

  // output connections
  assign {buf_z, buf_y, buf_x}                        = bout_data;
  assign {path_z_output, path_y_output, path_x_output} = s.path_out;
  assign {wake_z, wake_y, wake_x}                     = s.wake_out;
  assign path_out_valid     = s.path_vld;
  assign wake_valid         = s.wake_vld;
  assign reg_rdata          = s.rdata;
  assign wake_rate_override = s.cfg[I_ROUTE][`AFRMS_B_WISEL];
  assign wake_avg_count     = s.cfg[0][6:4];

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence raw_wake_seq;
    wsrc == afrms_pkg::AFRMS_WS_RAW && smp_valid;
  endsequence

  sequence both_bypass_seq;
    path_tick && s.cfg[I_ROUTE][4:3] == 2'b11 && !s.cfg[I_ROUTE][`AFRMS_B_RMSO];
  endsequence

  path_off_quiet_a: assert property (!path_engine_enable |=> !path_out_valid)
    else $error("path output while engine disabled");
  buf_raw_feed_a: assert property (!s.cfg[I_ROUTE][7] && smp_valid && smp_ready
    |-> (bin_valid && bin_data == smp) ##1 buf_valid)
    else $error("raw sample not offered to buffer");
  wake_raw_feed_a: assert property (raw_wake_seq |=> wake_valid
    && wake_x == $past(smp_x)) else $error("raw sample not sent to wake");
  wake_none_a: assert property (wsrc == afrms_pkg::AFRMS_WS_NONE |=> !wake_valid)
    else $error("wake data while path routed nowhere");
  route_write_a: assert property (reg_wr && reg_addr == `AFRMS_OFS_ROUTE |=>
    s.cfg[I_ROUTE] == ($past(reg_wdata) & 8'hfb)) else $error("route write lost");
  bypass_pass_a: assert property (both_bypass_seq |=>
    path_x_output == $past(s.avg_smp[0])) else $error("bypass altered sample");
  top_rate_a: assert property (path_engine_enable && !s.pend && rate_is_top() &&
    base_tick |-> path_tick) else $error("top rate missed a tick");
  rms_only_done_a: assert property (s.cfg[I_ROUTE][1] && path_engine_enable
    && path_tick && !rms_done |=> !path_out_valid) else $error("RMS output early");
  coef_top_zero_a: assert property (s.cfg[I_F1IA][7] == 1'b0
    && s.cfg[I_BAHI][7] == 1'b0) else $error("unused coefficient bit set");

  function automatic logic rate_is_top();
    return s.cfg[0][3:0] == 4'hf;
  endfunction : rate_is_top

endmodule : afrms_path

// ---- tb/test_afrms_path.sv ----
/*
  self-checking bench of the filter and rms path: registers, raw stream
  with buffer stall, filter and rms cases; assumes afrms_path, BASE_CYC 4
*/
`timescale 1ns/100ps

module test_afrms_path;
  // ----------------------------------------------------------------
  // signals and notes
  // ----------------------------------------------------------------
  localparam int BC = 4;
  logic        clock     = 1'b0;
  logic        resetn    = 1'b0;
  logic        en        = 1'b0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        smp_valid = 1'b0;
  logic        buf_ready = 1'b1;
  logic [2:0]  lac       = 3'h0;
  logic [47:0] smp       = '0;
  logic [7:0]  reg_rdata;
  logic        smp_ready, pv, bv, wv, wro;
  logic [15:0] px, py, pz, bx, by, bz, wx, wy, wz;
  logic [2:0]  wac;
  logic [47:0] rq[$], pq[$], bq[$], wq[$];
  int          gq[$];
  logic [31:0] rs          = 32'h0000_0049;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  int          last        = 0;
  logic        rd_seen     = 1'b0;
  logic [7:0]  msk [11]    = '{8'hff, 8'hfb, 8'h7f, 8'hff, 8'hff, 8'h7f,
                               8'hff, 8'hff, 8'h7f, 8'h1f, 8'hff};

  afrms_path #(.DW(16), .BASE_CYC(BC)) u_afrms_path (
    .clock(clock), .resetn(resetn), .path_engine_enable(en),
    .lowpower_average_count(lac), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_x(smp[15:0]),
    .smp_y(smp[31:16]), .smp_z(smp[47:32]), .path_out_valid(pv),
    .path_x_output(px), .path_y_output(py), .path_z_output(pz),
    .buf_valid(bv), .buf_ready(buf_ready), .buf_x(bx), .buf_y(by), .buf_z(bz),
    .wake_valid(wv), .wake_x(wx), .wake_y(wy), .wake_z(wz),
    .wake_rate_override(wro), .wake_avg_count(wac));

  // clock of 40 ns
  always #20 clock = ~clock;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  function automatic logic [15:0] fexp(input logic [1:0] k, input logic [15:0] v);
    case (k)
      2'h0: return v;
      2'h1: return {v[15], v[15:1]};
      2'h2: return 16'h0000;
      default: return v[15] ? 16'h0000 - v : v;
    endcase
  endfunction : fexp

  task automatic check(input string what, input logic [47:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic fail_wait();
    mismatches++;
    $display("wrong value wait expected done seen timeout");
    report_and_stop();
  endtask : fail_wait

  task automatic take(ref logic [47:0] q[$], input string what, input logic [47:0] seen);
    if (q.size() == 0) begin
      mismatches++;
      $display("wrong value %s expected none seen %h", what, seen);
    end else begin
      check(what, seen, q.pop_front());
    end
  endtask : take

  // monitor: each result takes the oldest note off its queue
  always @(posedge clock) begin
    cyc <= cyc + 1;
    rd_seen <= reg_rd;
    if (rd_seen) take(rq, "register", 48'(reg_rdata));
    if (wv) take(wq, "wake", {wz, wy, wx});
    if (bv && buf_ready) take(bq, "buffer", {bz, by, bx});
    if (pv) begin
      if (gq.size() > 0 && gq[0] > 0) check("gap", 48'(cyc - last), 48'(gq[0]));
      if (gq.size() > 0) void'(gq.pop_front());
      last <= cyc;
      take(pq, "path", {pz, py, px});
    end
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    rq.push_back(48'(e));
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
  endtask : rd

  task automatic drain_wait(input int lim);
    int n;
    n = 0;
    while (pq.size() + bq.size() + wq.size() + rq.size() > 0) begin
      @(negedge clock);
      n++;
      if (n > lim) fail_wait();
    end
  endtask : drain_wait

  // raw sample held until taken; the far side stalls at random
  task automatic send();
    logic [31:0] r;
    logic [47:0] w;
    int n;
    n = 0;
    r = xs();
    w = {r[15:0], r};
    @(negedge clock);
    smp_valid = 1'b1;
    smp = w;
    forever begin
      #1;
      wq.push_back(w);
      if (smp_ready === 1'b1) break;
      n++;
      if (n > 40) fail_wait();
      r = xs();
      @(negedge clock);
      buf_ready = r[0];
    end
    bq.push_back(w);
    @(negedge clock);
    smp_valid = 1'b0;
  endtask : send

  // one path setting run for three results, then disabled
  task automatic path_case(input logic [7:0] rate, route, ia, osh, input logic [1:0] k);
    logic [31:0] r;
    logic [47:0] w, e;
    int g;
    r = xs();
    w = {4'h0, r[31:20], 16'h0000 - {4'h0, r[23:12]}, 4'h0, r[11:0]};
    wr(8'h64, rate);
    wr(8'h65, route);
    wr(8'h66, ia);
    wr(8'h6e, osh);
    check("override", 48'(wro), 48'(route[6]));
    check("avg count", 48'(wac), 48'(rate[6:4]));
    @(negedge clock);
    smp_valid = 1'b1;
    smp = w;
    e = {fexp(k, w[47:32]), fexp(k, w[31:16]), fexp(k, w[15:0])};
    g = BC << (15 - rate[3:0]);
    if (route[1]) g = g << (rate[6:4] + 1);
    for (int i = 0; i < 3; i++) begin
      pq.push_back(e);
      bq.push_back(e);
      if (route[5]) wq.push_back(e);
      gq.push_back(i == 0 ? 0 : g);
    end
    // let the new sample reach the averager before the first tick
    @(negedge clock);
    en = 1'b1;
    wr(8'h6d, 8'h00);
    drain_wait(20 * g);
    en = 1'b0;
    repeat (2 * g) @(negedge clock);
    smp_valid = 1'b0;
  endtask : path_case

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0] d;
    logic [47:0] a, b, e;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check("reset ready", 48'(smp_ready), 48'h1);
    check("reset buf", 48'({bv, pv, wv}), 48'h0);
    resetn = 1'b1;
    for (int i = 0; i < 11; i++) rd(8'(8'h64 + i), i == 1 ? 8'h02 : 8'h00);
    rd(8'h63, 8'h00);
    for (int i = 0; i < 11; i++) begin
      r = xs();
      d = r[7:0] & (i == 0 ? 8'h7f : 8'hff);
      wr(8'(8'h64 + i), d);
      rd(8'(8'h64 + i), d & msk[i]);
    end
    wr(8'h6f, 8'hff);
    rd(8'h6f, 8'h00);
    for (int i = 0; i < 11; i++) wr(8'(8'h64 + i), 8'h00);
    drain_wait(20);
    $display("test done: registers");
    buf_ready = 1'b0;
    send();
    send();
    @(negedge clock);
    #1;
    check("refused", 48'(smp_ready), 48'h0);
    send();
    send();
    buf_ready = 1'b1;
    drain_wait(50);
    $display("test done: raw stream");
    path_case(8'h0d, 8'hd8, 8'h00, 8'h00, 2'h0);
    path_case(8'h0e, 8'hd0, 8'h40, 8'h00, 2'h0);
    path_case(8'h0e, 8'hd0, 8'h40, 8'h80, 2'h1);
    path_case(8'h0e, 8'hc8, 8'h00, 8'h00, 2'h2);
    path_case(8'h0e, 8'hc9, 8'h00, 8'h00, 2'h0);
    path_case(8'h1e, 8'hfa, 8'h00, 8'h00, 2'h3);
    path_case(8'h7f, 8'hfa, 8'h00, 8'h00, 2'h3);
    $display("test done: path cases");
    // two samples averaged into one result, both filters bypassed
    lac = 3'h1;
    wr(8'h64, 8'h0f);
    wr(8'h65, 8'hd8);
    r = xs();
    a = {r[15:0], r};
    r = xs();
    b = {r[15:0], r};
    @(negedge clock);
    smp_valid = 1'b1;
    smp = a;
    @(negedge clock);
    smp = b;
    @(negedge clock);
    smp_valid = 1'b0;
    for (int i = 0; i < 3; i++) begin
      e[16*i +: 16] = 16'(($signed({a[16*i+15], a[16*i +: 16]})
                        + $signed({b[16*i+15], b[16*i +: 16]})) >>> 1);
    end
    pq.push_back(e);
    bq.push_back(e);
    gq.push_back(0);
    en = 1'b1;
    drain_wait(80);
    en = 1'b0;
    lac = 3'h0;
    $display("test done: averaging");
    report_and_stop();
  end
endmodule : test_afrms_path
